// [adc_model.sv]
`timescale 1ns/10ps
module adc_model (
  input wire clk,
  input wire rst,
  input wire adc_start,
  input wire [1:0] exc_level,
  input wire chan_sel,
  input wire [13:0] t1,
  input wire [13:0] t2,
  output reg adc_done,
  output reg [13:0] adc_data
);
  reg [1:0] cnt_q;
  reg busy_q;
  reg flip_q;
  wire [13:0] t = chan_sel ? t2 : t1;
  // alternating error cancels when any even count is averaged
  wire [13:0] j = flip_q ? 14'h0004 : 14'h3ffc;
  wire [13:0] lvl = exc_level == 2'h0 ? 14'h0 : (exc_level == 2'h1 ? t + j : t);
  always @(posedge clk) begin
    adc_done <= 1'b0;
    // idle bus toggles so stale data never looks valid
    adc_data <= ~adc_data;
    if (rst) begin
      busy_q <= 1'b0;
      flip_q <= 1'b0;
      cnt_q <= 2'h0;
      adc_data <= 14'h0;
    end else if (adc_start) begin
      busy_q <= 1'b1;
      cnt_q <= 2'h0;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h1) begin
        busy_q <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= 14'h0400 + lvl;
        if (exc_level == 2'h2 && chan_sel) flip_q <= ~flip_q;
      end
    end
  end
endmodule

// [diode_avg16.v]
`timescale 1ns/10ps
`include "temp_readout_map.vh"

module diode_avg16 (
  input wire clk,
  input wire rst,
  input wire sample_valid,
  input wire signed [16:0] sample,
  output reg avg_valid,
  output reg signed [16:0] avg
);
  reg [3:0] cnt_q;
  reg signed [20:0] sum_q;
  wire signed [20:0] sum_d;

  assign sum_d = sum_q + {{4{sample[16]}}, sample};

  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
      sum_q <= 21'sh000000;
      avg_valid <= 1'b0;
      avg <= 17'sh00000;
    end else begin
      avg_valid <= 1'b0;
      if (sample_valid) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == `AVG_LAST) begin
          sum_q <= 21'sh000000;
          avg <= sum_d[16+`AVG_SHIFT:`AVG_SHIFT];
          avg_valid <= 1'b1;
        end else begin
          sum_q <= sum_d;
        end
      end
    end
  end
endmodule

// [remote_temp_result_readout.v]
`timescale 1ns/10ps
`include "temp_readout_map.vh"

module remote_temp_result_readout (
  input wire clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg adc_start,
  input wire adc_done,
  input wire [13:0] adc_data,
  output wire [1:0] exc_level,
  output wire chan_sel,
  output wire frozen
);
  localparam S_START = 1'b0;
  localparam S_WAIT = 1'b1;

  reg state_q;
  reg [1:0] phase_q;
  reg chan_q;
  reg [13:0] base_q;
  reg signed [14:0] dv1_q;
  reg [1:0] meas_valid_q;
  reg signed [16:0] meas_q;
  reg [7:0] cfg_q;
  reg freeze_q;
  reg freeze_d;
  reg [1:0] seen_q;
  reg [1:0] seen_d;
  wire signed [14:0] dv_now;
  wire [9:0] val_w0;
  wire [9:0] val_w1;

  function signed [17:0] off_quarters;
    input [7:0] off;
    input whole;
    begin
      if (whole)
        off_quarters = {{8{off[7]}}, off, 2'h0};
      else
        off_quarters = {{9{off[7]}}, off, 1'b0};
    end
  endfunction

  // saturate to the ten-bit field of the chosen format
  function [9:0] fmt_clamp;
    input signed [17:0] q;
    input twos;
    reg signed [17:0] b;
    begin
      b = q + `OFF64_BIAS;
      if (twos) begin
        if (q > `TWOS_MAX)
          fmt_clamp = `CLAMP_TWOS_HI;
        else if (q < `TWOS_MIN)
          fmt_clamp = `CLAMP_TWOS_LO;
        else
          fmt_clamp = q[9:0];
      end else begin
        if (b > `OFF64_MAX)
          fmt_clamp = `CLAMP_OFF64_HI;
        else if (b < 18'sh00000)
          fmt_clamp = `CLAMP_OFF64_LO;
        else
          fmt_clamp = b[9:0];
      end
    end
  endfunction

  // base, first multiple, base, second multiple
  assign exc_level = phase_q[0] ? (phase_q[1] ? `EXC_SECOND : `EXC_FIRST)
                                : `EXC_BASE;
  assign chan_sel = chan_q;
  assign frozen = freeze_q;
  assign dv_now = {1'b0, adc_data} - {1'b0, base_q};

  always @(posedge clk) begin
    if (rst) begin
      state_q <= S_START;
      phase_q <= 2'h0;
      chan_q <= 1'b0;
      base_q <= 14'h0000;
      dv1_q <= 15'sh0000;
      meas_valid_q <= 2'h0;
      meas_q <= 17'sh00000;
      adc_start <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      meas_valid_q <= 2'h0;
      case (state_q)
        S_START: begin
          adc_start <= 1'b1;
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (adc_done) begin
            state_q <= S_START;
            phase_q <= phase_q + 2'h1;
            if (!phase_q[0])
              base_q <= adc_data;
            else if (!phase_q[1])
              dv1_q <= dv_now;
            else begin
              // series resistance cancels in 2*dv1 - dv2
              meas_q <= ({{2{dv1_q[14]}}, dv1_q} <<< 1)
                        - {{2{dv_now[14]}}, dv_now};
              meas_valid_q <= chan_q ? 2'h2 : 2'h1;
              chan_q <= ~chan_q;
            end
          end
        end
        default: state_q <= S_START;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      localparam [7:0] OFF_ADDR = (g == 0) ? `ADDR_REMOTE1_OFFSET
                                           : `ADDR_REMOTE2_OFFSET;
      reg [7:0] off_q;
      reg [9:0] latest_q;
      reg [9:0] val_q;
      wire avg_valid;
      wire signed [16:0] avg;
      wire signed [17:0] sum_w;

      diode_avg16 u_avg (
        .clk(clk),
        .rst(rst),
        .sample_valid(meas_valid_q[g]),
        .sample(meas_q),
        .avg_valid(avg_valid),
        .avg(avg)
      );

      assign sum_w = {avg[16], avg}
                     + off_quarters(off_q, cfg_q[`CFG_OFFSET_WHOLE_BIT]);

      always @(posedge clk) begin
        if (rst) begin
          off_q <= `OFFSET_RESET;
          latest_q <= `VALUE_RESET;
          val_q <= `VALUE_RESET;
        end else begin
          if (reg_wr && reg_addr == OFF_ADDR)
            off_q <= reg_wdata;
          if (avg_valid)
            latest_q <= fmt_clamp(sum_w, cfg_q[`CFG_TWOS_BIT]);
          // newest result loads once thawed
          // next state, so the freezing read edge loads nothing new
          if (!freeze_d)
            val_q <= latest_q;
        end
      end
    end
  endgenerate

  assign val_w0 = chan[0].val_q;
  assign val_w1 = chan[1].val_q;

  // freeze until both value registers read
  always @* begin
    freeze_d = freeze_q;
    seen_d = seen_q;
    if (reg_rd && reg_addr == `ADDR_FRACTION) begin
      freeze_d = 1'b1;
      seen_d = 2'h0;
    end else if (reg_rd && freeze_q) begin
      if (reg_addr == `ADDR_REMOTE1_VALUE)
        seen_d[0] = 1'b1;
      if (reg_addr == `ADDR_REMOTE2_VALUE)
        seen_d[1] = 1'b1;
      if (seen_d == 2'h3)
        freeze_d = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      cfg_q <= `CFG_RESET;
      freeze_q <= 1'b0;
      seen_q <= 2'h0;
      reg_rdata <= 8'h00;
    end else begin
      freeze_q <= freeze_d;
      seen_q <= seen_d;
      if (reg_wr && reg_addr == `ADDR_TEMP_CONFIG)
        cfg_q <= reg_wdata;
      if (reg_rd) begin
        case (reg_addr)
          // upper eight bits, readable any time
          `ADDR_REMOTE1_VALUE: reg_rdata <= val_w0[9:2];
          `ADDR_REMOTE2_VALUE: reg_rdata <= val_w1[9:2];
          // quarter degree bits in shared register
          `ADDR_FRACTION: begin
            reg_rdata <= 8'h00;
            reg_rdata[`FRAC_REMOTE1_LSB+1:`FRAC_REMOTE1_LSB] <= val_w0[1:0];
            reg_rdata[`FRAC_REMOTE2_LSB+1:`FRAC_REMOTE2_LSB] <= val_w1[1:0];
          end
          `ADDR_REMOTE1_OFFSET: reg_rdata <= chan[0].off_q;
          `ADDR_REMOTE2_OFFSET: reg_rdata <= chan[1].off_q;
          `ADDR_TEMP_CONFIG: reg_rdata <= cfg_q;
          // unmapped reads return zero
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// [remote_temp_result_readout_tb.sv]
`timescale 1ns/10ps
`include "temp_readout_map.vh"
module remote_temp_result_readout_tb;
  reg clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  reg [13:0] t1 = 14'h0065, t2 = 14'h00ca;
  wire [7:0] reg_rdata;
  wire adc_start, adc_done, chan_sel, frozen;
  wire [13:0] adc_data;
  wire [1:0] exc_level;
  integer num_errors = 0, compares = 0, n, k;
  always #5 clk = ~clk;
  remote_temp_result_readout i_dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_start(adc_start),
    .adc_done(adc_done), .adc_data(adc_data), .exc_level(exc_level),
    .chan_sel(chan_sel), .frozen(frozen));
  adc_model i_adc (.clk(clk), .rst(rst), .adc_start(adc_start),
    .exc_level(exc_level), .chan_sel(chan_sel), .t1(t1), .t2(t2),
    .adc_done(adc_done), .adc_data(adc_data));
  task give_verdict;
    begin
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task check(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk) #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(posedge clk) #1 reg_wr = 0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk) #1 reg_addr = a;
      reg_rd = 1;
      @(posedge clk) #1 reg_rd = 0;
      check(reg_rdata, exp);
    end
  endtask
  // two full windows of both channels, so results are all fresh
  task settle;
    begin
      n = 0;
      for (k = 0; k < 5000 && n < 300; k = k + 1) begin
        @(posedge clk);
        #1 n = n + adc_start;
      end
      if (n < 300) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t: converter stalled", $time);
        give_verdict;
      end
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    rd(`ADDR_REMOTE1_OFFSET, `OFFSET_RESET);
    rd(`ADDR_TEMP_CONFIG, `CFG_RESET);
    rd(8'h00, 8'h00);
    wr(`ADDR_FRACTION, 8'hff);
    $display("test reset done");
    settle;
    rd(`ADDR_REMOTE1_VALUE, 8'h19);
    check({7'h00, frozen}, 8'h00);
    rd(`ADDR_FRACTION, 8'h84);
    check({7'h00, frozen}, 8'h01);
    t1 = 14'h0080;
    settle;
    rd(`ADDR_REMOTE1_VALUE, 8'h19);
    check({7'h00, frozen}, 8'h01);
    rd(`ADDR_REMOTE2_VALUE, 8'h32);
    check({7'h00, frozen}, 8'h00);
    settle;
    rd(`ADDR_REMOTE1_VALUE, 8'h20);
    $display("test freeze done");
    wr(`ADDR_REMOTE1_OFFSET, 8'hfc);
    rd(`ADDR_REMOTE1_OFFSET, 8'hfc);
    settle;
    rd(`ADDR_REMOTE1_VALUE, 8'h1e);
    wr(`ADDR_TEMP_CONFIG, 8'h03);
    settle;
    rd(`ADDR_REMOTE1_VALUE, 8'h1c);
    wr(`ADDR_TEMP_CONFIG, 8'h02);
    settle;
    rd(`ADDR_REMOTE1_VALUE, 8'h5c);
    rd(`ADDR_REMOTE2_VALUE, 8'h72);
    $display("test offset done");
    give_verdict;
  end
endmodule

// [temp_readout_map.vh]
`ifndef TEMP_READOUT_MAP_VH
`define TEMP_READOUT_MAP_VH

// register offsets
`define ADDR_REMOTE1_VALUE 8'h25
`define ADDR_REMOTE2_VALUE 8'h27
`define ADDR_REMOTE1_OFFSET 8'h70
`define ADDR_REMOTE2_OFFSET 8'h72
`define ADDR_FRACTION 8'h77
`define ADDR_TEMP_CONFIG 8'h7c

// temperature config fields
`define CFG_TWOS_BIT 0
`define CFG_OFFSET_WHOLE_BIT 1
`define CFG_RESET 8'h01

// fraction register field positions, per remote channel
`define FRAC_REMOTE1_LSB 2
`define FRAC_REMOTE2_LSB 6

// reset values
`define OFFSET_RESET 8'h00
`define VALUE_RESET 10'h000

// excitation levels
`define EXC_BASE 2'h0
`define EXC_FIRST 2'h1
`define EXC_SECOND 2'h2

// averaging: samples per result, as a last-index count and a shift
`define AVG_LAST 4'hf
`define AVG_SHIFT 4

// result limits in quarter degrees
`define TWOS_MAX 18'sh001ff
`define TWOS_MIN 18'sh3fe00
`define OFF64_BIAS 18'sh00100
`define OFF64_MAX 18'sh003ff

// ten-bit codes a clamped result saturates to
`define CLAMP_TWOS_HI 10'h1ff
`define CLAMP_TWOS_LO 10'h200
`define CLAMP_OFF64_HI 10'h3ff
`define CLAMP_OFF64_LO 10'h000

`endif

// [temp_readout_monitor.sv]
`timescale 1ns/10ps
`include "temp_readout_map.vh"
module temp_readout_monitor (
  input wire clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire adc_start,
  input wire adc_done,
  input wire [1:0] exc_level,
  input wire chan_sel,
  input wire frozen
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_frac_rd;
    reg_rd && reg_addr == `ADDR_FRACTION;
  endsequence
  sequence s_sample_req;
    adc_start;
  endsequence
  a_frac_freeze: assert property (s_frac_rd |=> frozen)
    else $error("no freeze after fraction read");
  a_frozen_hold: assert property (frozen && !reg_rd |=> frozen)
    else $error("freeze dropped without a read");
  a_plain_nofreeze: assert property
    (!frozen && !(reg_rd && reg_addr == `ADDR_FRACTION) |=> !frozen)
    else $error("freeze without fraction read");
  a_frac_spare: assert property (s_frac_rd |=>
    reg_rdata[1:0] == 2'h0 && reg_rdata[5:4] == 2'h0)
    else $error("unused fraction bits set");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_start_pulse: assert property (s_sample_req |=> !adc_start)
    else $error("start pulse too long");
  a_exc_steady: assert property (s_sample_req |=>
    ($stable(exc_level) && $stable(chan_sel))[*2])
    else $error("excitation moved during sample");
  a_base_next: assert property (adc_done && exc_level == `EXC_FIRST |->
    ##[1:3] (adc_start && exc_level == `EXC_BASE))
    else $error("base level not after first multiple");
endmodule
bind remote_temp_result_readout temp_readout_monitor i_mon (.clk(clk),
  .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .adc_start(adc_start), .adc_done(adc_done), .exc_level(exc_level),
  .chan_sel(chan_sel), .frozen(frozen));
